/* logic/gci_monitor_ci_controller.sv */
// Purpose: GCI monitor and C/I channel controller with AXI4-Lite registers
// Assumes: link clock far slower than aclk; frame sync marks slot bit 0
// Notes: slot word is monitor byte, C/I bits, A bit, E bit, MSB first
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module gci_monitor_ci_controller
    import gci_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // GCI link
    input  wire link_in_s          link,
    output logic                   tx_data
);
    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    function automatic logic [7:0] badr(input logic [7:0] idx);
        badr = {idx[5:0], 2'b00};
    endfunction : badr

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [15:0] m;
        m = {{8{s[1]}}, {8{s[0]}}};
        merge = (old & ~m) | (d[15:0] & m);
    endfunction : merge

    // Bus state
    logic              aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0]        aw_addr, next_aw_addr;
    logic [31:0]       w_data, next_w_data;
    logic [3:0]        w_strb, next_w_strb;
    logic [1:0]        next_bresp, next_rresp;
    logic              next_bvalid, next_rvalid;
    logic [31:0]       next_rdata, rd_val;
    logic              wr_fire, rd_hit, wr_hit;
    // Core state
    mode_s             md, next_md;
    logic [15:0]       mrx, mtx, crx, ctx;
    logic [15:0]       next_mrx, next_mtx, next_crx, next_ctx;
    logic [3:0]        ev, next_ev, ev_set;
    logic              hs, next_hs;
    mon_tx_e           mst, next_mst;
    logic [1:0]        ab_e, next_ab_e, ab_a, next_ab_a;
    logic              a_ack, next_a_ack, acked, next_acked;
    logic              msg_open, next_msg_open;
    logic [7:0]        prev_byte, next_prev_byte;
    logic              prev_ok, next_prev_ok;
    logic [5:0]        ci_cur, next_ci_cur, ci_last, next_ci_last;
    logic [5:0]        ci_cand, next_ci_cand, ci_in;
    logic              cand_ok, next_cand_ok;
    logic [3:0]        pos, next_pos, cur_pos;
    logic              active, next_active;
    logic [15:0]       sh, next_sh, ws, rw, tw;
    logic              txd, next_txd, next_tx_data;
    // Link synchronisers
    logic              lclk_s1, lclk_s2, lclk_s3, fs_s1, fs_s2, rxd_s1, rxd_s2;
    // Frame decode helpers
    logic              rise, bit_ev, fe, lin, tx_on, rx_on, mon_on;
    logic              a_out, e_out, a_in, e_in;
    logic [7:0]        mbyte, mon_out;

    // Handshakes offered while the holding slot is free
    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    assign arready = !rvalid;
    assign wr_fire = aw_held && w_held && !bvalid;

    // Read decode
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0;
        unique case (araddr[7:0])
            badr(MON_RX_IDX): rd_val = {16'h0, mrx};
            badr(MON_TX_IDX): rd_val = {16'h0, mtx};
            badr(CI_RX_IDX):  rd_val = {16'h0, crx};
            badr(CI_TX_IDX):  rd_val = {16'h0, ctx};
            badr(STATE_IDX):  rd_val = {16'h0, pos, active, a_ack, acked, msg_open,
                                        prev_ok, cand_ok, ab_a, ab_e, mst};
            badr(MRX_SC_IDX): rd_val = {24'h0, prev_byte};
            badr(MTX_SC_IDX): rd_val = {24'h0, mon_out};
            badr(CRX_SC_IDX): rd_val = {26'h0, ci_cand};
            badr(CTX_SC_IDX): rd_val = {26'h0, ci_cur};
            MODE_ADDR:        rd_val = {16'h0, md};
            EVENT_ADDR:       rd_val = {28'h0, ev};
            CMD_ADDR:         rd_val = 32'h0;
            HS_ADDR:          rd_val = {31'h0, hs};
            default:          rd_hit = 1'b0;
        endcase
        if ((araddr >> 8) != '0) begin
            rd_hit = 1'b0;
        end
    end

    // Bus channel next state
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_rdata   = rdata;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr[7:0];
            if ((awaddr >> 8) != '0) begin
                next_aw_addr = 8'hff;
            end
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_val;
            next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h0;
            w_held  <= 1'b0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            rvalid  <= 1'b0;
            rresp   <= RESP_OKAY;
            rdata   <= 32'h0;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held  <= next_w_held;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
        end
    end

    // Two-flop synchronisers for the link pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {lclk_s1, lclk_s2, lclk_s3} <= 3'h0;
            {fs_s1, fs_s2, rxd_s1, rxd_s2} <= 4'hf;
        end else begin
            {lclk_s1, lclk_s2, lclk_s3} <= {link.clk, lclk_s1, lclk_s2};
            {fs_s1, fs_s2} <= {link.sync, fs_s1};
            {rxd_s1, rxd_s2} <= {link.data, rxd_s1};
        end
    end

    // Slot framing and word assembly
    always_comb begin
        rise    = lclk_s2 && !lclk_s3;
        cur_pos = fs_s2 ? 4'h0 : pos + 4'h1;
        bit_ev  = rise && (fs_s2 || active);
        fe      = bit_ev && (cur_pos == md.slot_bit_count);
        lin     = (md.diagnostic_select == DIAG_LOOP) ? txd : rxd_s2;
        ws      = {sh[14:0], lin};
        rw      = ws << (4'hf - md.slot_bit_count);
        mbyte   = rw[15:8];
        ci_in   = md.scit_select ? rw[7:2] : {2'b00, rw[7:4]};
        a_in    = md.scit_select ? rw[1] : rw[3];
        e_in    = md.scit_select ? rw[0] : rw[2];
        tx_on   = md.transmit_on && (md.protocol_select == PROT_GCI);
        rx_on   = md.receive_on && (md.protocol_select == PROT_GCI);
        mon_on  = md.monitor_support;
        mon_out = (mst == TX_SEND && mon_on) ? mtx[7:0] : 8'hff;
        e_out   = !(mst == TX_SEND && mon_on);
        a_out   = !(a_ack && mon_on) || ab_a != 2'h0;
        tw      = md.scit_select ? {mon_out, ci_cur, a_out, e_out}
                                 : {mon_out, ci_cur[3:0], a_out, e_out, 2'b11};
    end

    // Channel processing, descriptors, events and commands
    always_comb begin
        next_md = md; next_mrx = mrx; next_mtx = mtx;
        next_crx = crx; next_ctx = ctx; next_hs = hs;
        next_mst = mst; next_ab_e = ab_e; next_ab_a = ab_a;
        next_a_ack = a_ack; next_acked = acked; next_msg_open = msg_open;
        next_prev_byte = prev_byte; next_prev_ok = prev_ok;
        next_ci_cur = ci_cur; next_ci_last = ci_last;
        next_ci_cand = ci_cand; next_cand_ok = cand_ok;
        next_pos = bit_ev ? cur_pos : pos;
        next_active = bit_ev ? (cur_pos != md.slot_bit_count) : active;
        next_sh = bit_ev ? ws : sh;
        next_txd = txd;
        ev_set = 4'h0;
        wr_hit = 1'b1;
        if (bit_ev) begin
            next_txd = tx_on ? tw[4'hf - cur_pos] : 1'b1;
        end else if (rise) begin
            next_txd = 1'b1;
        end
        if (fe) begin
            if (ab_a != 2'h0) next_ab_a = ab_a - 2'h1;
            next_a_ack = 1'b0;
            // C/I transmit: value repeats, new value taken from a ready descriptor
            if (tx_on && ctx[FLAG_BIT]) begin
                next_ci_cur = md.scit_select ? ctx[7:2] : {2'b00, ctx[5:2]};
                next_ctx[FLAG_BIT] = 1'b0;
                ev_set[EV_CI_SENT] = 1'b1;
            end
            // C/I receive with double last-look when scit_select is clear, single look when it is set
            if (rx_on) begin
                next_ci_cand = ci_in;
                next_cand_ok = ci_in != ci_last;
                if (ci_in != ci_last &&
                    (md.scit_select || (cand_ok && ci_in == ci_cand))) begin
                    next_ci_last = ci_in;
                    next_cand_ok = 1'b0;
                    if (crx[FLAG_BIT]) begin
                        next_crx = {8'h00, ci_in, 2'b00};
                        ev_set[EV_CI_GOT] = 1'b1;
                    end
                end
            end
            // Monitor transmit
            if (tx_on && mon_on) begin
                unique case (mst)
                    TX_IDLE: if (mtx[FLAG_BIT]) next_mst = TX_SEND;
                    TX_SEND: if (!hs || !a_in) begin
                        next_mst = TX_IDLE;
                        next_mtx[FLAG_BIT] = 1'b0;
                        ev_set[EV_MON_SENT] = 1'b1;
                    end
                    TX_ABORT: begin
                        next_ab_e = ab_e - 2'h1;
                        if (ab_e == 2'h1) next_mst = TX_IDLE;
                    end
                    default: next_mst = TX_IDLE;
                endcase
            end
            // Monitor receive
            if (rx_on && mon_on) begin
                next_prev_byte = mbyte;
                next_prev_ok = !e_in;
                if (!hs) begin
                    if (mrx[FLAG_BIT] && !e_in) begin
                        next_mrx = {8'h00, mbyte};
                        ev_set[EV_MON_GOT] = 1'b1;
                    end
                end else if (!e_in) begin
                    next_msg_open = 1'b1;
                    if (mbyte != prev_byte) next_acked = 1'b0;
                    if (!(prev_ok && mbyte == prev_byte)) begin
                        next_mrx[MISMATCH_BIT] = prev_ok;
                    end else if (mrx[FLAG_BIT] && !acked) begin
                        next_mrx = {8'h00, mbyte};
                        next_acked = 1'b1;
                        next_a_ack = 1'b1;
                        ev_set[EV_MON_GOT] = 1'b1;
                    end
                end else if (msg_open && mrx[FLAG_BIT]) begin
                    next_mrx = 16'h0;
                    next_mrx[LAST_BIT] = 1'b1;
                    next_msg_open = 1'b0;
                    next_acked = 1'b0;
                    ev_set[EV_MON_GOT] = 1'b1;
                end
            end
        end
        // Register writes and commands
        next_ev = ev;
        if (wr_fire) begin
            unique case (aw_addr)
                badr(MON_RX_IDX): next_mrx = merge(mrx, w_data, w_strb);
                badr(MON_TX_IDX): next_mtx = merge(mtx, w_data, w_strb);
                badr(CI_RX_IDX):  next_crx = merge(crx, w_data, w_strb);
                badr(CI_TX_IDX):  next_ctx = merge(ctx, w_data, w_strb);
                badr(STATE_IDX), badr(MRX_SC_IDX), badr(MTX_SC_IDX),
                badr(CRX_SC_IDX), badr(CTX_SC_IDX): wr_hit = 1'b1;
                MODE_ADDR:  next_md = mode_s'(merge(md, w_data, w_strb));
                EVENT_ADDR: if (w_strb[0]) next_ev = ev & ~w_data[3:0];
                HS_ADDR:    if (w_strb[0]) next_hs = w_data[0];
                CMD_ADDR: if (w_strb[0]) begin
                    if (w_data[CMD_RX_ABORT] && hs) next_ab_a = ABORT_FRAMES;
                    if (w_data[CMD_TX_TIMEOUT] && hs) begin
                        next_mst = TX_ABORT;
                        next_ab_e = ABORT_FRAMES;
                    end
                    if (w_data[CMD_INIT]) begin
                        next_mrx = RX_DESC_RESET; next_crx = RX_DESC_RESET;
                        next_mtx = TX_DESC_RESET; next_ctx = TX_DESC_RESET;
                        next_mst = TX_IDLE; next_ab_e = 2'h0; next_ab_a = 2'h0;
                        next_a_ack = 1'b0; next_acked = 1'b0; next_msg_open = 1'b0;
                        next_prev_ok = 1'b0; next_prev_byte = 8'h0;
                        next_ci_cur = 6'h0; next_ci_last = 6'h0;
                        next_ci_cand = 6'h0; next_cand_ok = 1'b0;
                    end
                end
                default: wr_hit = 1'b0;
            endcase
        end
        next_ev = next_ev | ev_set;
        unique case (md.diagnostic_select)
            DIAG_ECHO: next_tx_data = rxd_s2;
            DIAG_LOOP: next_tx_data = 1'b1;
            default:   next_tx_data = txd;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            md <= mode_s'(MODE_RESET);
            mrx <= RX_DESC_RESET; mtx <= TX_DESC_RESET;
            crx <= RX_DESC_RESET; ctx <= TX_DESC_RESET;
            ev <= 4'h0; hs <= 1'b0; mst <= TX_IDLE;
            ab_e <= 2'h0; ab_a <= 2'h0;
            a_ack <= 1'b0; acked <= 1'b0; msg_open <= 1'b0;
            prev_byte <= 8'h0; prev_ok <= 1'b0;
            ci_cur <= 6'h0; ci_last <= 6'h0; ci_cand <= 6'h0; cand_ok <= 1'b0;
            pos <= 4'h0; active <= 1'b0; sh <= 16'hffff;
            txd <= 1'b1; tx_data <= 1'b1;
        end else begin
            md <= next_md;
            mrx <= next_mrx; mtx <= next_mtx;
            crx <= next_crx; ctx <= next_ctx;
            ev <= next_ev; hs <= next_hs; mst <= next_mst;
            ab_e <= next_ab_e; ab_a <= next_ab_a;
            a_ack <= next_a_ack; acked <= next_acked; msg_open <= next_msg_open;
            prev_byte <= next_prev_byte; prev_ok <= next_prev_ok;
            ci_cur <= next_ci_cur; ci_last <= next_ci_last;
            ci_cand <= next_ci_cand; cand_ok <= next_cand_ok;
            pos <= next_pos; active <= next_active; sh <= next_sh;
            txd <= next_txd; tx_data <= next_tx_data;
        end
    end
endmodule : gci_monitor_ci_controller
`default_nettype wire

/* include/gci_pkg.sv */
// Purpose: constants and types for the GCI monitor and C/I controller
// Assumes: 32-bit AXI4-Lite register bus, byte addresses 8 bits wide
// Notes: parameter area word index times four gives the byte address
package gci_pkg;
    // Word indices of the parameter area
    localparam logic [7:0] MON_RX_IDX = 8'h00;
    localparam logic [7:0] MON_TX_IDX = 8'h02;
    localparam logic [7:0] CI_RX_IDX  = 8'h04;
    localparam logic [7:0] CI_TX_IDX  = 8'h06;
    localparam logic [7:0] STATE_IDX  = 8'h08;
    localparam logic [7:0] MRX_SC_IDX = 8'h0c;
    localparam logic [7:0] MTX_SC_IDX = 8'h0e;
    localparam logic [7:0] CRX_SC_IDX = 8'h10;
    localparam logic [7:0] CTX_SC_IDX = 8'h12;
    // Control register byte addresses
    localparam logic [7:0] MODE_ADDR  = 8'h80;
    localparam logic [7:0] EVENT_ADDR = 8'h84;
    localparam logic [7:0] CMD_ADDR   = 8'h88;
    localparam logic [7:0] HS_ADDR    = 8'h8c;
    // Descriptor fields
    localparam int FLAG_BIT     = 15;
    localparam int LAST_BIT     = 14;
    localparam int MISMATCH_BIT = 12;
    localparam logic [15:0] RX_DESC_RESET = 16'h8000;
    localparam logic [15:0] TX_DESC_RESET = 16'h0000;
    localparam logic [15:0] MODE_RESET    = 16'h0000;
    // Event and command bits
    localparam int EV_MON_GOT  = 0;
    localparam int EV_MON_SENT = 1;
    localparam int EV_CI_GOT   = 2;
    localparam int EV_CI_SENT  = 3;
    localparam int CMD_INIT       = 0;
    localparam int CMD_RX_ABORT   = 1;
    localparam int CMD_TX_TIMEOUT = 2;
    localparam logic [1:0] ABORT_FRAMES = 2'h2;
    // Mode encodings
    localparam logic [1:0] PROT_GCI    = 2'h0;
    localparam logic [1:0] PROT_UART   = 2'h2;
    localparam logic [1:0] PROT_TRANSP = 2'h3;
    localparam logic [1:0] DIAG_NORMAL = 2'h0;
    localparam logic [1:0] DIAG_LOOP   = 2'h1;
    localparam logic [1:0] DIAG_ECHO   = 2'h2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Mode register layout
    typedef struct packed {
        logic       rsvd15;
        logic [3:0] slot_bit_count;
        logic       monitor_support;
        logic       rsvd9;
        logic       scit_select;
        logic [1:0] rsvd7_6;
        logic [1:0] protocol_select;
        logic [1:0] diagnostic_select;
        logic       transmit_on;
        logic       receive_on;
    } mode_s;
    // Link pins from the transceiver side
    typedef struct packed {
        logic clk;
        logic sync;
        logic data;
    } link_in_s;
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_SEND  = 2'b01,
        TX_ABORT = 2'b10
    } mon_tx_e;
endpackage : gci_pkg

/* bench/gci_ctrl_monitor.sv */
// Purpose: port checks for the GCI controller
// Assumes: single aclk domain
// Notes: attached by the bind below
`timescale 1ns/10ps
`default_nettype none
module gci_ctrl_monitor (
    // Watched bus and link ports
    input wire logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid,
    input wire logic        bready, arvalid, arready, rvalid, rready, tx_data,
    input wire logic [1:0]  bresp,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    chk_ar_block: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    chk_aw_block: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    chk_r_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    chk_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    chk_b_code: assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h2)
        else $error("bad write code");
    chk_tx_idle: assert property (disable iff (1'b0) !aresetn |=> tx_data)
        else $error("link not idle in reset");
    cover property (bvalid && bready && bresp == 2'h2);
    cover property (rvalid && rready);
    cover property ($fell(tx_data));
endmodule : gci_ctrl_monitor
bind gci_monitor_ci_controller gci_ctrl_monitor u_chk (.aclk, .aresetn, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .tx_data,
    .bresp, .rdata);
`default_nettype wire

/* bench/gci_link_model.sv */
// Purpose: far-side transceiver stand-in on the GCI link
// Assumes: 64 ns bit clock, still between frames
// Notes: transmit pin sampled late in each bit
`timescale 1ns/10ps
`default_nettype none
module gci_link_model import gci_pkg::*; (
    output var link_in_s  link,
    input wire logic      tx_data
);
    initial link = '{clk: 1'b0, sync: 1'b0, data: 1'b1};
    // One 16-bit slot, MSB first, sync high during bit 0
    task automatic frame(input logic [15:0] w, output logic [15:0] got);
        for (int i = 15; i >= 0; i--) begin
            link.sync = (i == 15);
            link.data = w[i];
            #8 link.clk = 1'b1;
            #32 link.clk = 1'b0;
            #23 got[i] = tx_data;
            #1;
        end
        link.sync = 1'b0;
        link.data = ~w[0]; // Released line shows no stale bit
    endtask : frame
endmodule : gci_link_model
`default_nettype wire

/* bench/gci_monitor_ci_controller_test.sv */
// Purpose: self-checking bench for the GCI controller
// Assumes: frames come from the link model
// Notes: C/I paths checked against a small behavioural model
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch %0t %h %h", $time, (a), (e)); end end
module gci_monitor_ci_controller_test import gci_pkg::*; ;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, tx_data, on = 0, ch1 = 0, txv = 0, full = 0;
    logic mon = 0, mv = 0, mfull = 0, echo = 0;
    logic [7:0] awaddr = 0, araddr = 0, ev = 0, mb = 8'hff, mtb = 0;
    logic [31:0] wdata = 0, rdata, d, m;
    logic [1:0] bresp, rresp, r;
    logic [5:0] cur_tx, last = 0, prev = 0, x, z;
    logic [15:0] cirx;
    link_in_s link;
    int n_fail = 0, n_tests = 0, cyc = 0, mq = 0;
    logic [7:0] ra [6] = '{8'h80, 8'h00, 8'h08, 8'h10, 8'h18, 8'h84};
    logic [15:0] rv [6] = '{16'h0, 16'h8000, 16'h0, 16'h8000, 16'h0, 16'h0};
    logic [31:0] md [4] = '{32'h6800, 32'h6823, 32'h6833, 32'h6808};
    gci_monitor_ci_controller DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .link, .tx_data);
    gci_link_model lm (.link, .tx_data);
    initial forever #4 aclk = ~aclk;
    // Hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin n_fail++; summarize(); end
    end
    task automatic summarize();
        if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // Bus master: handshakes judged at the rising edge, one idle edge after each answer
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        r = bresp;
        bready <= 0;
        @(posedge aclk);
    endtask : wr
    // Read accept comes one cycle after the answer so the answer must stand
    task automatic rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid && !rready) rready <= 1;
        end while (!(rvalid && rready));
        d = rdata; r = rresp;
        rready <= 0;
        @(posedge aclk);
    endtask : rd
    task automatic regs();
        rd(EVENT_ADDR); `CHK(d, {24'h0, ev})
        rd(8'h10); `CHK(d[15:0], full ? cirx : 16'h8000)
    endtask : regs
    // One frame on the link, then the model's view of the slot end
    task automatic slot(input logic [5:0] ci);
        logic [15:0] g, w;
        logic [5:0] tci;
        w = ch1 ? {mb, ci, 1'b1, ~mv} : {8'hff, ci[3:0], 4'hf};
        lm.frame(w, g);
        repeat (4) @(posedge aclk);
        tci = ch1 ? g[7:2] : {2'b0, g[7:4]};
        if (on && txv) `CHK(tci, cur_tx)
        if (!on) `CHK(g, echo ? w : 16'hffff)
        // Transparent monitor: byte goes out one slot after it is taken
        if (on && mon) begin
            `CHK({g[15:8], g[0]}, (mq == 2) ? {mtb, 1'b0} : 9'h1ff)
            if (mq == 2) begin mq = 0; ev[EV_MON_SENT] = 1; end
            else if (mq == 1) mq = 2;
            if (mv && !mfull) begin mfull = 1; ev[EV_MON_GOT] = 1; end
        end
        if (on) begin
            if (!txv) begin txv = 1; ev[EV_CI_SENT] = 1; end
            if (ci != last && (ch1 || ci == prev)) begin
                if (!full) begin cirx = {8'h0, ci, 2'b0}; full = 1; ev[EV_CI_GOT] = 1; end
                last = ci;
            end
            prev = ci;
        end
    endtask : slot
    initial begin
        void'($urandom(77));
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        foreach (ra[i]) begin rd(ra[i]); `CHK(d[15:0], rv[i]) end
        rd(8'h60); `CHK(r, RESP_SLVERR)
        wr(8'h60, 32'h0); `CHK(r, RESP_SLVERR)
        m = $urandom & 32'h7d3f;
        wr(MODE_ADDR, m); rd(MODE_ADDR); `CHK(d, m)
        wr(MODE_ADDR, 32'h6800); wr(MODE_ADDR, 32'h6803); on = 1;
        cur_tx = 6'($urandom_range(15));
        wr(8'h18, {16'h0, 8'h80, cur_tx, 2'b0});
        repeat (3) slot(6'h0);
        rd(8'h18); `CHK(d[15:0], {8'h0, cur_tx, 2'b0})
        x = 6'($urandom_range(15, 1));
        slot(x); regs(); slot(x); regs();
        slot(x ^ 6'h1); slot(x ^ 6'h1); regs();
        wr(8'h10, 32'h8000); full = 0; wr(EVENT_ADDR, 32'hf); ev = 0; regs();
        foreach (md[i]) begin
            wr(MODE_ADDR, md[i]); on = 0; echo = (i == 3);
            slot(x ^ 6'h2); slot(x ^ 6'h2); regs();
        end
        wr(MODE_ADDR, 32'h7903); on = 1; ch1 = 1;
        z = 6'h20 | 6'($urandom_range(31));
        slot(z); regs(); slot(z); regs();
        wr(MODE_ADDR, 32'h7d03); mon = 1; mv = 1; mb = 8'($urandom); mtb = 8'($urandom);
        wr(8'h08, {16'h0, 8'h80, mtb}); mq = 1;
        repeat (3) slot(z);
        regs();
        rd(8'h00); `CHK(d[15:0], {8'h0, mb})
        rd(8'h08); `CHK(d[15:0], {8'h0, mtb})
        wr(CMD_ADDR, 32'h1);
        for (int i = 1; i < 5; i++) begin rd(ra[i]); `CHK(d[15:0], rv[i]) end
        summarize();
    end
endmodule : gci_monitor_ci_controller_test
`default_nettype wire
